// *** include/pec_consts.svh ***
// Offsets, field positions, reset values and timing counts of the probe unit.
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

`define PEC_ADDR_W 8
`define PEC_OFS_CTRL 8'h00
`define PEC_OFS_CMD 8'h04
`define PEC_OFS_ENABLE 8'h08
`define PEC_OFS_EXTCTRL 8'h0c
`define PEC_OFS_SEL1 8'h10
`define PEC_OFS_SEL2 8'h14
`define PEC_OFS_STATUS 8'h18
`define PEC_OFS_EVCNT 8'h1c
`define PEC_OFS_VAL1P 8'h20
`define PEC_OFS_VAL1N 8'h24
`define PEC_OFS_VAL2P 8'h28
`define PEC_OFS_VAL2N 8'h2c
`define PEC_OFS_DIFF1 8'h30
`define PEC_OFS_DIFF2 8'h34
`define PEC_OFS_MISS 8'h38
`define PEC_OFS_TIME 8'h3c
`define PEC_OFS_WLO1 8'h40
`define PEC_OFS_WHI1 8'h44
`define PEC_OFS_WLO2 8'h48
`define PEC_OFS_WHI2 8'h4c

`define PEC_CTRL_MASK 32'h0000013f
`define PEC_CTRL_POS1 0
`define PEC_CTRL_NEG1 1
`define PEC_CTRL_MODE1 4
`define PEC_CTRL_AUTO 8
`define PEC_EXT_MASK 32'h0000007f
`define PEC_EXT_TIME1 0
`define PEC_EXT_WIN1 2
`define PEC_EXT_MISS1 4
`define PEC_EXT_BOTH 6
`define PEC_SEL_MASK 32'h00000007
`define PEC_NUM_SRC 7
`define PEC_RST_WORD 32'h00000000

`define PEC_CLK_HZ 40000000
`define PEC_TICK_US 1
`define PEC_US_CYCLES (`PEC_CLK_HZ / 1000000 * `PEC_TICK_US)

`define PEC_RESP_OKAY 2'b00
`define PEC_RESP_SLVERR 2'b10

`endif

// *** include/pec_pkg.sv ***
// Types shared by the probe edge capture unit.
package pec_pkg;
  typedef logic [31:0] pec_word_t;
  typedef logic [2:0] pec_sel_t;
  typedef enum logic [1:0] {
    PEC_WIN_OUT = 2'b00,
    PEC_WIN_IN_LO = 2'b01,
    PEC_WIN_IN_HI = 2'b10
  } pec_win_t;
endpackage : pec_pkg

// *** logic/pec_probe_edge_capture.sv ***
// Two-channel probe edge capture unit with an AXI4-Lite register slave.
// Function
// - Probe inputs are binary levels with edges
// - Mirror probe levels while detection is active
// - Dual trigger from input one freezes level two
// - Capture needs polarity, command and enable together
// - Independent positive and negative edge enables
// - Auto command on entering operating mode
// - Single or continuous mode per probe
// - Single mode latches first trigger only
// - Continuous mode latches every trigger
// - Time capture ignores source selection
// - Position window with optional miss monitor
// - Both channels may trigger from input one
// - Per-probe selector picks one of seven sources
// - Time capture gives relative microsecond stamps
// - Time differences reach at least 1000 s
// - Four holding values, one per probe and polarity
// - Store difference of opposite polarity captures
// - Count events per probe and polarity
// - Enable re-arm clears counts, flags, misses
`timescale 1ns/10ps
`include "pec_consts.svh"

module pec_probe_edge_capture (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] probeIn,
  input wire logic operatingMode,
  input wire pec_pkg::pec_word_t srcFeedback1,
  input wire pec_pkg::pec_word_t srcFeedback2,
  input wire pec_pkg::pec_word_t srcMeasEncoder,
  input wire pec_pkg::pec_word_t srcCamAngle,
  input wire pec_pkg::pec_word_t srcCyclePos,
  input wire pec_pkg::pec_word_t srcMasterResult,
  input wire pec_pkg::pec_word_t srcMasterEffective,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pec_pkg::*;

  localparam logic [5:0] US_CYCLES = 6'(`PEC_US_CYCLES);

  // Picks the selected position source; unknown codes give zero.
  function automatic pec_word_t pickSource(input pec_sel_t sel,
      input pec_word_t s0, input pec_word_t s1, input pec_word_t s2,
      input pec_word_t s3, input pec_word_t s4, input pec_word_t s5,
      input pec_word_t s6);
    pec_word_t r;
    r = '0;
    case (sel)
      3'h0: r = s0;
      3'h1: r = s1;
      3'h2: r = s2;
      3'h3: r = s3;
      3'h4: r = s4;
      3'h5: r = s5;
      3'h6: r = s6;
      default: r = '0;
    endcase
    return r;
  endfunction : pickSource

  // Merges write data into a register under the byte strobes.
  function automatic pec_word_t mergeStrb(input pec_word_t old,
      input pec_word_t data, input logic [3:0] strb, input pec_word_t mask);
    pec_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction : mergeStrb

  pec_word_t ctrl;
  pec_word_t extCtrl;
  pec_word_t selReg [2];
  pec_word_t winLo [2];
  pec_word_t winHi [2];
  logic [1:0] probeEnable;
  logic [1:0] enPrev;
  logic captureCmd;
  logic cmdPrev;
  logic opModePrev;
  logic [2:0] sync0;
  logic [2:0] sync1;
  logic [1:0] lvl;
  logic [1:0] lvlPrev;
  logic [1:0] lvlStatus;
  logic [5:0] usDiv;
  pec_word_t usCount;
  pec_word_t holdVal [4];
  pec_word_t diffVal [2];
  logic [3:0] haveVal;
  logic [7:0] evCount [4];
  logic [3:0] latched;
  logic [1:0] singleDone;
  logic [7:0] missCount [2];
  pec_win_t winState [2];
  logic [1:0] winHit;
  logic [1:0] prevBelow;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  pec_word_t wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic [1:0] enRise;
  logic [1:0] rawPos;
  logic [1:0] rawNeg;
  logic [1:0] trigPos;
  logic [1:0] trigNeg;
  logic [1:0] timeMode;
  logic [1:0] winEnable;
  logic [1:0] winOk;
  logic [1:0] inWin;
  logic [1:0] below;
  logic [3:0] qual;
  logic [1:0] singleBlock;
  pec_word_t capVal [2];
  pec_word_t next_rdata;
  logic [1:0] next_rresp;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Input synchroniser; a level change counts once stages two and three agree.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync0 <= 3'h0;
      sync1 <= 3'h0;
      lvl <= 2'h0;
      lvlPrev <= 2'h0;
    end else begin
      sync0 <= {sync0[1:0], probeIn[0]};
      sync1 <= {sync1[1:0], probeIn[1]};
      if (sync0[1] == sync0[2]) begin
        lvl[0] <= sync0[2];
      end
      if (sync1[1] == sync1[2]) begin
        lvl[1] <= sync1[2];
      end
      lvlPrev <= lvl;
    end
  end

  always_comb begin
    rawPos = lvl & ~lvlPrev;
    rawNeg = ~lvl & lvlPrev;
    trigPos[0] = rawPos[0];
    trigNeg[0] = rawNeg[0];
    trigPos[1] = extCtrl[`PEC_EXT_BOTH] ? rawPos[0] : rawPos[1];
    trigNeg[1] = extCtrl[`PEC_EXT_BOTH] ? rawNeg[0] : rawNeg[1];
    enRise = probeEnable & ~enPrev;
    for (int p = 0; p < 2; p++) begin
      timeMode[p] = extCtrl[`PEC_EXT_TIME1 + p];
      winEnable[p] = extCtrl[`PEC_EXT_WIN1 + p] && !timeMode[p];
      capVal[p] = timeMode[p] ? usCount :
          pickSource(selReg[p][2:0], srcFeedback1, srcFeedback2,
          srcMeasEncoder, srcCamAngle, srcCyclePos, srcMasterResult,
          srcMasterEffective);
      below[p] = capVal[p] < winLo[p];
      inWin[p] = !below[p] && capVal[p] <= winHi[p];
      winOk[p] = !winEnable[p] || inWin[p];
      singleBlock[p] = !ctrl[`PEC_CTRL_MODE1 + p] && singleDone[p]
          && !enRise[p];
      qual[2*p] = trigPos[p] && ctrl[`PEC_CTRL_POS1 + 2*p] && captureCmd
          && probeEnable[p] && winOk[p] && !singleBlock[p];
      qual[2*p+1] = trigNeg[p] && ctrl[`PEC_CTRL_NEG1 + 2*p] && captureCmd
          && probeEnable[p] && winOk[p] && !singleBlock[p];
    end
  end

  // Level status follows the inputs only while capture is active, input two only without dual trigger.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lvlStatus <= 2'h0;
    end else if (captureCmd) begin
      lvlStatus[0] <= lvl[0];
      if (!extCtrl[`PEC_EXT_BOTH]) begin
        lvlStatus[1] <= lvl[1];
      end
    end
  end

  // Free running microsecond stamp; 32 bits span over 4000 s.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      usDiv <= 6'h00;
      usCount <= 32'h00000000;
    end else if (usDiv == US_CYCLES - 6'h01) begin
      usDiv <= 6'h00;
      usCount <= usCount + 32'h00000001;
    end else begin
      usDiv <= usDiv + 6'h01;
    end
  end

  // Capture command, set directly in operating mode or on mode entry.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      captureCmd <= 1'b0;
      cmdPrev <= 1'b0;
      opModePrev <= 1'b0;
    end else begin
      opModePrev <= operatingMode;
      cmdPrev <= captureCmd;
      if (!operatingMode) begin
        captureCmd <= 1'b0;
      end else if (!opModePrev && ctrl[`PEC_CTRL_AUTO]) begin
        captureCmd <= 1'b1;
      end else if (doWrite && awAddr == `PEC_OFS_CMD && wStrb[0]) begin
        captureCmd <= wData[0];
      end
    end
  end

  // Capture datapath, counters and window tracking per probe.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enPrev <= 2'h0;
      singleDone <= 2'h0;
      haveVal <= 4'h0;
      latched <= 4'h0;
      winHit <= 2'h0;
      prevBelow <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        holdVal[i] <= 32'h00000000;
        evCount[i] <= 8'h00;
      end
      for (int p = 0; p < 2; p++) begin
        diffVal[p] <= 32'h00000000;
        missCount[p] <= 8'h00;
        winState[p] <= PEC_WIN_OUT;
      end
    end else begin
      enPrev <= probeEnable;
      if (captureCmd != cmdPrev) begin
        latched <= 4'h0;
      end
      for (int p = 0; p < 2; p++) begin
        if (enRise[p]) begin
          singleDone[p] <= 1'b0;
          haveVal[2*p +: 2] <= 2'h0;
          latched[2*p +: 2] <= 2'h0;
          evCount[2*p] <= 8'h00;
          evCount[2*p+1] <= 8'h00;
          missCount[p] <= 8'h00;
          winHit[p] <= 1'b0;
        end else begin
          if (winEnable[p]) begin
            if (winState[p] == PEC_WIN_OUT) begin
              prevBelow[p] <= below[p];
              if (inWin[p]) begin
                winState[p] <= prevBelow[p] ? PEC_WIN_IN_LO : PEC_WIN_IN_HI;
              end
            end else if (!inWin[p]) begin
              winState[p] <= PEC_WIN_OUT;
              prevBelow[p] <= below[p];
              winHit[p] <= 1'b0;
              if (((winState[p] == PEC_WIN_IN_LO) != below[p]) && !winHit[p]
                  && extCtrl[`PEC_EXT_MISS1 + p] && missCount[p] != 8'hff) begin
                missCount[p] <= missCount[p] + 8'h01;
              end
            end
          end else begin
            winState[p] <= PEC_WIN_OUT;
          end
        end
        for (int e = 0; e < 2; e++) begin
          if (qual[2*p+e]) begin
            holdVal[2*p+e] <= capVal[p];
            haveVal[2*p+e] <= 1'b1;
            latched[2*p+e] <= 1'b1;
            evCount[2*p+e] <= enRise[p] ? 8'h01
                : evCount[2*p+e] + 8'h01;
            singleDone[p] <= 1'b1;
            if (haveVal[2*p+1-e] && !enRise[p]) begin
              diffVal[p] <= capVal[p] - holdVal[2*p+1-e];
            end
            if (winEnable[p]) begin
              winHit[p] <= 1'b1;
              missCount[p] <= 8'h00;
            end
          end
        end
      end
    end
  end

  // AXI4-Lite write channel and configuration registers.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PEC_RESP_OKAY;
      ctrl <= `PEC_RST_WORD;
      extCtrl <= `PEC_RST_WORD;
      probeEnable <= 2'h0;
      for (int p = 0; p < 2; p++) begin
        selReg[p] <= `PEC_RST_WORD;
        winLo[p] <= `PEC_RST_WORD;
        winHi[p] <= `PEC_RST_WORD;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PEC_RESP_OKAY;
        if (awAddr == `PEC_OFS_CTRL) begin
          ctrl <= mergeStrb(ctrl, wData, wStrb, `PEC_CTRL_MASK);
        end else if (awAddr == `PEC_OFS_CMD) begin
          s_axi_bresp <= `PEC_RESP_OKAY;
        end else if (awAddr == `PEC_OFS_ENABLE) begin
          if (wStrb[0]) begin
            probeEnable <= wData[1:0];
          end
        end else if (awAddr == `PEC_OFS_EXTCTRL) begin
          extCtrl <= mergeStrb(extCtrl, wData, wStrb, `PEC_EXT_MASK);
        end else if (awAddr == `PEC_OFS_SEL1) begin
          selReg[0] <= mergeStrb(selReg[0], wData, wStrb, `PEC_SEL_MASK);
        end else if (awAddr == `PEC_OFS_SEL2) begin
          selReg[1] <= mergeStrb(selReg[1], wData, wStrb, `PEC_SEL_MASK);
        end else if (awAddr == `PEC_OFS_WLO1) begin
          winLo[0] <= mergeStrb(winLo[0], wData, wStrb, '1);
        end else if (awAddr == `PEC_OFS_WHI1) begin
          winHi[0] <= mergeStrb(winHi[0], wData, wStrb, '1);
        end else if (awAddr == `PEC_OFS_WLO2) begin
          winLo[1] <= mergeStrb(winLo[1], wData, wStrb, '1);
        end else if (awAddr == `PEC_OFS_WHI2) begin
          winHi[1] <= mergeStrb(winHi[1], wData, wStrb, '1);
        end else begin
          s_axi_bresp <= `PEC_RESP_SLVERR;
        end
      end
    end
  end

  // Read decode; unmapped addresses return zero with an error response.
  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = `PEC_RESP_OKAY;
    if (s_axi_araddr == `PEC_OFS_CTRL) begin
      next_rdata = ctrl;
    end else if (s_axi_araddr == `PEC_OFS_CMD) begin
      next_rdata = {31'h00000000, captureCmd};
    end else if (s_axi_araddr == `PEC_OFS_ENABLE) begin
      next_rdata = {30'h00000000, probeEnable};
    end else if (s_axi_araddr == `PEC_OFS_EXTCTRL) begin
      next_rdata = extCtrl;
    end else if (s_axi_araddr == `PEC_OFS_SEL1) begin
      next_rdata = selReg[0];
    end else if (s_axi_araddr == `PEC_OFS_SEL2) begin
      next_rdata = selReg[1];
    end else if (s_axi_araddr == `PEC_OFS_STATUS) begin
      next_rdata = {22'h000000, singleDone, latched, operatingMode,
          captureCmd, lvlStatus};
    end else if (s_axi_araddr == `PEC_OFS_EVCNT) begin
      next_rdata = {evCount[3], evCount[2], evCount[1], evCount[0]};
    end else if (s_axi_araddr == `PEC_OFS_VAL1P) begin
      next_rdata = holdVal[0];
    end else if (s_axi_araddr == `PEC_OFS_VAL1N) begin
      next_rdata = holdVal[1];
    end else if (s_axi_araddr == `PEC_OFS_VAL2P) begin
      next_rdata = holdVal[2];
    end else if (s_axi_araddr == `PEC_OFS_VAL2N) begin
      next_rdata = holdVal[3];
    end else if (s_axi_araddr == `PEC_OFS_DIFF1) begin
      next_rdata = diffVal[0];
    end else if (s_axi_araddr == `PEC_OFS_DIFF2) begin
      next_rdata = diffVal[1];
    end else if (s_axi_araddr == `PEC_OFS_MISS) begin
      next_rdata = {16'h0000, missCount[1], missCount[0]};
    end else if (s_axi_araddr == `PEC_OFS_TIME) begin
      next_rdata = usCount;
    end else if (s_axi_araddr == `PEC_OFS_WLO1) begin
      next_rdata = winLo[0];
    end else if (s_axi_araddr == `PEC_OFS_WHI1) begin
      next_rdata = winHi[0];
    end else if (s_axi_araddr == `PEC_OFS_WLO2) begin
      next_rdata = winLo[1];
    end else if (s_axi_araddr == `PEC_OFS_WHI2) begin
      next_rdata = winHi[1];
    end else begin
      next_rresp = `PEC_RESP_SLVERR;
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pec_probe_edge_capture

// *** tb/pec_probe_edge_capture_asserts.sv ***
// Bus handshake checker bound to the probe edge capture unit.
`timescale 1ns/10ps
module pec_probe_edge_capture_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic operatingMode,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_W_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write accepted while response pending");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("response repeated");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read data repeated");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h4c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_CMD_PARAM: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h04 && !operatingMode && !$past(operatingMode) |=>
    s_axi_rdata[0] == 1'b0) else $error("command set in parameter mode");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : pec_probe_edge_capture_asserts
bind pec_probe_edge_capture pec_probe_edge_capture_asserts u_chk (
  .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .operatingMode);

// *** tb/pec_probe_switch.sv ***
// Model of the probe switches wired to the two fast inputs.
`timescale 1ns/10ps
module pec_probe_switch (
  input wire logic clk_sys,
  output logic [1:0] probeIn
);
  // Bit 0 is probe one, bit 1 is probe two.
  initial probeIn = 2'b00;
  // Drives a clean binary level and holds it well past capture.
  task setPin(input int i, input logic v);
    @(posedge clk_sys);
    probeIn[i] <= v;
    repeat (12) @(posedge clk_sys);
  endtask : setPin
endmodule : pec_probe_switch

// *** tb/pec_probe_edge_capture_tb.sv ***
// Self-checking testbench of the probe edge capture unit.
`timescale 1ns/10ps
module pec_probe_edge_capture_tb;
  import pec_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} pec_exp_t;
  logic clk_sys = 0, sys_rst = 1, operatingMode = 0;
  logic [1:0] probeIn;
  pec_word_t srcs [7];
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, hi, keep;
  pec_exp_t rq[$];
  logic [1:0] bq[$];
  int numErrors = 0, testsRun = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  initial foreach (srcs[i]) srcs[i] = 0;
  pec_probe_switch u_sw (.clk_sys(clk_sys), .probeIn(probeIn));
  pec_probe_edge_capture u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .probeIn(probeIn), .operatingMode(operatingMode),
    .srcFeedback1(srcs[0]), .srcFeedback2(srcs[1]),
    .srcMeasEncoder(srcs[2]), .srcCamAngle(srcs[3]),
    .srcCyclePos(srcs[4]), .srcMasterResult(srcs[5]),
    .srcMasterEffective(srcs[6]), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task tallyAndFinish();
    $display("comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tallyAndFinish
  task chkRead(input pec_exp_t e, input logic [31:0] g, input logic [1:0] r);
    testsRun++;
    if (((g & e.m) !== (e.d & e.m)) || (r !== e.r)) begin
      numErrors++;
      $display("unexpected read at %0t: %h/%h want %h/%h", $time, g, r,
        e.d, e.r);
    end
  endtask : chkRead
  task chkResp(input logic [1:0] e, input logic [1:0] g);
    testsRun++;
    if (g !== e) begin
      numErrors++;
      $display("unexpected bresp at %0t: %h want %h", $time, g, e);
    end
  endtask : chkResp
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      chkRead(rq.pop_front(), rdata, rresp);
    end
    if (bvalid === 1'b1 && bready && bq.size() > 0) begin
      chkResp(bq.pop_front(), bresp);
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      numErrors++;
      tallyAndFinish();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw;
    bq.push_back(e);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(posedge clk_sys);
      if (pa && awready) begin
        awvalid <= 0;
        pa = 0;
      end
      if (pw && wready) begin
        wvalid <= 0;
        pw = 0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic [1:0] e = 2'b00);
    rq.push_back('{d, m, e});
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 0;
  endtask : rd
  task newSrc();
    @(posedge clk_sys);
    foreach (srcs[i]) srcs[i] <= $urandom();
  endtask : newSrc
  initial begin
    void'($urandom(77));
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    rd(8'h00, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    rd(8'h50, 32'h0, 32'hffffffff, 2'b10);
    wr(8'h50, 32'h1, 2'b10);
    wr(8'h04, 32'h1, 2'b00);
    rd(8'h18, 32'h0, 32'h4);
    rd(8'h04, 32'h0, 32'h1);
    $display("test reset and refusals done");
    wr(8'h00, 32'h0000011f, 2'b00);
    @(posedge clk_sys);
    operatingMode <= 1;
    repeat (3) @(posedge clk_sys);
    rd(8'h18, 32'hc, 32'hc);
    wr(8'h08, 32'h3, 2'b00);
    wr(8'h14, 32'h6, 2'b00);
    for (int k = 0; k < 7; k++) begin
      wr(8'h10, k, 2'b00);
      newSrc();
      u_sw.setPin(0, 1);
      hi = srcs[k];
      rd(8'h20, hi, 32'hffffffff);
      rd(8'h18, 32'h11, 32'h11);
      newSrc();
      u_sw.setPin(0, 0);
      rd(8'h24, srcs[k], 32'hffffffff);
      rd(8'h30, srcs[k] - hi, 32'hffffffff);
    end
    keep = srcs[6];
    rd(8'h1c, 32'h0707, 32'hffff);
    $display("test continuous capture done");
    newSrc();
    u_sw.setPin(1, 1);
    hi = srcs[6];
    newSrc();
    u_sw.setPin(1, 0);
    rd(8'h28, hi, 32'hffffffff);
    rd(8'h2c, 32'h0, 32'hffffffff);
    $display("test single capture done");
    wr(8'h08, 32'h0, 2'b00);
    wr(8'h08, 32'h3, 2'b00);
    rd(8'h1c, 32'h0, 32'hffffffff);
    wr(8'h0c, 32'h40, 2'b00);
    u_sw.setPin(1, 1);
    newSrc();
    u_sw.setPin(0, 1);
    hi = srcs[6];
    rd(8'h28, hi, 32'hffffffff);
    rd(8'h20, hi, 32'hffffffff);
    rd(8'h18, 32'h1, 32'h3);
    $display("test dual trigger done");
    wr(8'h08, 32'h0, 2'b00);
    newSrc();
    u_sw.setPin(0, 0);
    rd(8'h24, keep, 32'hffffffff);
    @(posedge clk_sys);
    operatingMode <= 0;
    wr(8'h08, 32'h3, 2'b00);
    newSrc();
    u_sw.setPin(0, 1);
    rd(8'h20, hi, 32'hffffffff);
    $display("test blocked capture done");
    wr(8'h0c, 32'h1, 2'b00);
    @(posedge clk_sys);
    operatingMode <= 1;
    repeat (3) @(posedge clk_sys);
    wr(8'h04, 32'h0, 2'b00);
    rd(8'h04, 32'h0, 32'h1);
    wr(8'h04, 32'h1, 2'b00);
    rd(8'h04, 32'h1, 32'h1);
    u_sw.setPin(0, 0);
    repeat (387) @(posedge clk_sys);
    u_sw.setPin(0, 1);
    rd(8'h30, 32'h0000000a, 32'hffffffff);
    $display("test time capture done");
    wr(8'h40, 32'h100, 2'b00);
    wr(8'h44, 32'h1ff, 2'b00);
    wr(8'h10, 32'h0, 2'b00);
    wr(8'h0c, 32'h14, 2'b00);
    @(posedge clk_sys);
    srcs[0] <= 32'h10;
    @(posedge clk_sys);
    srcs[0] <= 32'h150;
    @(posedge clk_sys);
    srcs[0] <= 32'h300;
    @(posedge clk_sys);
    srcs[0] <= 32'h180;
    rd(8'h38, 32'h1, 32'hffff);
    u_sw.setPin(0, 0);
    rd(8'h24, 32'h180, 32'hffffffff);
    rd(8'h38, 32'h0, 32'hffff);
    @(posedge clk_sys);
    srcs[0] <= 32'h300;
    u_sw.setPin(0, 1);
    rd(8'h1c, 32'h0201, 32'hffff);
    $display("test window done");
    repeat (4) @(posedge clk_sys);
    tallyAndFinish();
  end
endmodule : pec_probe_edge_capture_tb
